// ---- verilog/fsf_flag_offset.v ----
/*
 * Status flag generation and offset register access decode for a dual-clock
 * FIFO. Write, read and serial load clocks arrive as pins and are sampled in
 * the system clock; each of their rising edges becomes a one-cycle event.
 * Assumes those pin clocks run well below a quarter of the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fsf_regs.vh"

// Function
// - flag timing mode is sampled at master reset and held until the next.
// - synchronous mode: almost full changes only on write clock edges.
// - synchronous mode: almost empty changes only on read clock edges.
// - asynchronous mode: almost full falls on write edge, rises on read edge.
// - asynchronous mode: almost empty falls on a read clock edge.
// - asynchronous mode: almost empty rises on a write clock edge.
// - standard mode flags decode from word count with thresholds n, D/2+1, D-m, D.
// - fall-through flags use the same thresholds shifted up by one word.
// - parallel offset reads present registers in that same order.
// - serial enable low shifts one serial bit per serial clock edge.
// - serial load runs empty offset LSB first to full offset MSB, 20 bits.
// - empty offset n and full offset m set the almost flag thresholds.
// - master reset loads one of eight defaults chosen by three select pins.
// - master reset homes both offset pointers; partial reset leaves them.
module fsf_flag_offset (
   // system
   input wire clk,
   input wire arst_n,
   // pin clocks
   input wire write_clock,
   input wire read_clock,
   input wire serial_load_clock,
   // resets and configuration pins
   input wire master_reset_n,
   input wire partial_reset_n,
   input wire flag_timing_select,
   input wire first_word_fall_through,
   input wire [1:0] offset_select,
   // access control pins
   input wire offset_load_select,
   input wire write_enable_n,
   input wire read_enable_n,
   input wire serial_enable_n,
   input wire serial_data_in,
   input wire [`FSF_LO_W-1:0] data_in,
   // status flags, active low unless named otherwise
   output reg empty_flag,
   output reg output_valid_flag,
   output reg almost_empty_flag,
   output reg half_full_flag,
   output reg almost_full_flag,
   output reg full_flag,
   output reg input_room_flag,
   // memory access strobes and word count
   output reg mem_write_pulse,
   output reg mem_read_pulse,
   output reg [`FSF_CNT_W-1:0] word_count,
   // offset read-back stream
   output reg [`FSF_DATA_W-1:0] offset_out_data,
   output reg offset_out_valid,
   input wire offset_out_ready,
   output reg offset_read_stall
);
   reg rst_a_q;
   reg rst_n_q;
   wire wr_rise;
   wire rd_rise;
   wire sc_rise;
   wire [`FSF_CTL_W-1:0] ctl;

   // reset release through two flops
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_a_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_a_q <= 1'b1;
         rst_n_q <= rst_a_q;
      end
   end

   fsf_pin_sync #(.W(1)) u_wclk (
      .clk(clk), .rst_n(rst_n_q), .pin_in(write_clock), .level_q(), .rise_q(wr_rise));
   fsf_pin_sync #(.W(1)) u_rclk (
      .clk(clk), .rst_n(rst_n_q), .pin_in(read_clock), .level_q(), .rise_q(rd_rise));
   fsf_pin_sync #(.W(1)) u_sclk (
      .clk(clk), .rst_n(rst_n_q), .pin_in(serial_load_clock), .level_q(),
      .rise_q(sc_rise));
   // controls share the clocks' latency so they stay aligned with the edges
   fsf_pin_sync #(.W(`FSF_CTL_W)) u_ctl (
      .clk(clk), .rst_n(rst_n_q),
      .pin_in({data_in, offset_select[0], offset_select[1], first_word_fall_through,
               flag_timing_select, serial_data_in, serial_enable_n, read_enable_n,
               write_enable_n, offset_load_select, partial_reset_n, master_reset_n}),
      .level_q(ctl), .rise_q());

   wire mrst_act = ~ctl[`FSF_B_MRST];
   wire prs_act = ~ctl[`FSF_B_PRS];
   wire lsel = ctl[`FSF_B_LSEL];
   wire wen_n = ctl[`FSF_B_WEN];
   wire ren_n = ctl[`FSF_B_REN];
   wire sena_n = ctl[`FSF_B_SENA];
   wire [`FSF_LO_W-1:0] din = ctl[`FSF_B_DAT +: `FSF_LO_W];

   // configuration caught during master reset
   reg sync_mode_q;
   reg fall_q;
   reg serial_mode_q;
   reg [`FSF_SER_BITS-1:0] ofs_q;
   reg [1:0] wptr_q;
   reg [1:0] rptr_q;
   reg [`FSF_OFS_W-1:0] def_ofs;

   wire [`FSF_OFS_W-1:0] n_ofs = ofs_q[`FSF_OFS_W-1:0];
   wire [`FSF_OFS_W-1:0] m_ofs = ofs_q[`FSF_SER_BITS-1:`FSF_OFS_W];

   always @* begin
      case ({lsel, ctl[`FSF_B_FS1], ctl[`FSF_B_FS0]})
         3'b010: def_ofs = `FSF_DEF_010;
         3'b001: def_ofs = `FSF_DEF_001;
         3'b000: def_ofs = `FSF_DEF_000;
         3'b011: def_ofs = `FSF_DEF_011;
         3'b100: def_ofs = `FSF_DEF_100;
         3'b110: def_ofs = `FSF_DEF_110;
         3'b101: def_ofs = `FSF_DEF_101;
         default: def_ofs = `FSF_DEF_111;
      endcase
   end

   // access decode
   reg [1:0] buf_cnt_q;
   wire buf_in_ready = (buf_cnt_q != 2'h2);
   wire ofs_wr = wr_rise & ~lsel & ~wen_n & ren_n & sena_n & ~serial_mode_q;
   wire ofs_rd_req = rd_rise & ~lsel & ~ren_n & wen_n & sena_n;
   wire ofs_rd = ofs_rd_req & buf_in_ready;
   wire ser_sh = sc_rise & ~lsel & ~sena_n & wen_n & ren_n & serial_mode_q;

   // offset registers and pointers
   always @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sync_mode_q <= 1'b0;
         fall_q <= 1'b0;
         serial_mode_q <= 1'b0;
         ofs_q <= {`FSF_SER_BITS{1'b0}};
         wptr_q <= `FSF_PTR_E_LO;
         rptr_q <= `FSF_PTR_E_LO;
      end else if (mrst_act) begin
         sync_mode_q <= ctl[`FSF_B_FTS];
         fall_q <= ctl[`FSF_B_FALL];
         serial_mode_q <= lsel;
         ofs_q <= {def_ofs, def_ofs};
         wptr_q <= `FSF_PTR_E_LO;
         rptr_q <= `FSF_PTR_E_LO;
      end else begin
         if (ser_sh) begin
            ofs_q <= {ctl[`FSF_B_SIN], ofs_q[`FSF_SER_BITS-1:1]};
         end else if (ofs_wr) begin
            case (wptr_q)
               `FSF_PTR_E_LO: ofs_q[`FSF_LO_W-1:0] <= din;
               `FSF_PTR_E_HI: ofs_q[`FSF_OFS_W-1] <= din[0];
               `FSF_PTR_F_LO: ofs_q[`FSF_OFS_W +: `FSF_LO_W] <= din;
               default: ofs_q[`FSF_SER_BITS-1] <= din[0];
            endcase
            wptr_q <= wptr_q + 2'h1;
         end
         if (ofs_rd) begin
            rptr_q <= rptr_q + 2'h1;
         end
      end
   end

   // read-back word for the current read pointer
   reg [`FSF_LO_W-1:0] rd_word;
   always @* begin
      case (rptr_q)
         `FSF_PTR_E_LO: rd_word = ofs_q[`FSF_LO_W-1:0];
         `FSF_PTR_E_HI: rd_word = {{(`FSF_LO_W-1){1'b0}}, ofs_q[`FSF_OFS_W-1]};
         `FSF_PTR_F_LO: rd_word = ofs_q[`FSF_OFS_W +: `FSF_LO_W];
         default: rd_word = {{(`FSF_LO_W-1){1'b0}}, ofs_q[`FSF_SER_BITS-1]};
      endcase
   end

   // two-entry buffer so a stalled reader loses no offset word
   reg [`FSF_DATA_W-1:0] buf_q0;
   reg [`FSF_DATA_W-1:0] buf_q1;
   wire pop = offset_out_valid & offset_out_ready;
   wire [`FSF_DATA_W-1:0] push_word = {{(`FSF_DATA_W-`FSF_LO_W){1'b0}}, rd_word};
   wire [1:0] cnt_nx = buf_cnt_q + {1'b0, ofs_rd} - {1'b0, pop};
   wire [`FSF_DATA_W-1:0] head_nx = pop ? ((buf_cnt_q == 2'h1) ? push_word : buf_q1) :
      ((buf_cnt_q == 2'h0) ? push_word : buf_q0);

   always @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         buf_cnt_q <= 2'h0;
         buf_q0 <= {`FSF_DATA_W{1'b0}};
         buf_q1 <= {`FSF_DATA_W{1'b0}};
         offset_out_data <= {`FSF_DATA_W{1'b0}};
         offset_out_valid <= 1'b0;
         offset_read_stall <= 1'b0;
      end else begin
         offset_read_stall <= ofs_rd_req & ~buf_in_ready;
         case ({ofs_rd, pop})
            2'b10: begin
               if (buf_cnt_q == 2'h0) begin
                  buf_q0 <= push_word;
               end else begin
                  buf_q1 <= push_word;
               end
               buf_cnt_q <= buf_cnt_q + 2'h1;
            end
            2'b01: begin
               buf_q0 <= buf_q1;
               buf_cnt_q <= buf_cnt_q - 2'h1;
            end
            2'b11: begin
               if (buf_cnt_q == 2'h1) begin
                  buf_q0 <= push_word;
               end else begin
                  buf_q0 <= buf_q1;
                  buf_q1 <= push_word;
               end
            end
            default: begin
               buf_cnt_q <= buf_cnt_q;
            end
         endcase
         // output stage takes the next head, so a popped word never shows twice
         offset_out_valid <= (cnt_nx != 2'h0);
         offset_out_data <= head_nx;
      end
   end

   // word count and flags
   wire [`FSF_CNT_W-1:0] cap = `FSF_DEPTH + {{(`FSF_CNT_W-1){1'b0}}, fall_q};
   wire mem_wr = wr_rise & lsel & ~wen_n & (word_count != cap);
   wire mem_rd = rd_rise & lsel & ~ren_n & (word_count != {`FSF_CNT_W{1'b0}});
   reg [`FSF_CNT_W-1:0] cnt_d;

   always @* begin
      cnt_d = word_count;
      if (mem_wr & ~mem_rd) begin
         cnt_d = word_count + {{(`FSF_CNT_W-1){1'b0}}, 1'b1};
      end else if (mem_rd & ~mem_wr) begin
         cnt_d = word_count - {{(`FSF_CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // fall-through shifts every threshold up by one word
   wire [`FSF_CNT_W:0] sh = {{`FSF_CNT_W{1'b0}}, fall_q};
   wire [`FSF_CNT_W:0] cnt_x = {1'b0, cnt_d};
   wire ae_cond = cnt_x <= ({2'b00, n_ofs} + sh);
   wire half_cond = cnt_x >= ({1'b0, `FSF_HALF_P1} + sh);
   wire af_cond = (cnt_x + {2'b00, m_ofs}) >= ({1'b0, `FSF_DEPTH} + sh);
   wire zero_cond = (cnt_d == {`FSF_CNT_W{1'b0}});
   wire cap_cond = (cnt_d == cap);

   always @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         word_count <= {`FSF_CNT_W{1'b0}};
         empty_flag <= 1'b0;
         output_valid_flag <= 1'b1;
         almost_empty_flag <= 1'b0;
         half_full_flag <= 1'b1;
         almost_full_flag <= 1'b1;
         full_flag <= 1'b1;
         input_room_flag <= 1'b0;
         mem_write_pulse <= 1'b0;
         mem_read_pulse <= 1'b0;
      end else if (mrst_act | prs_act) begin
         word_count <= {`FSF_CNT_W{1'b0}};
         empty_flag <= 1'b0;
         output_valid_flag <= 1'b1;
         almost_empty_flag <= 1'b0;
         half_full_flag <= 1'b1;
         almost_full_flag <= 1'b1;
         full_flag <= 1'b1;
         input_room_flag <= 1'b0;
         mem_write_pulse <= 1'b0;
         mem_read_pulse <= 1'b0;
      end else begin
         word_count <= cnt_d;
         mem_write_pulse <= mem_wr;
         mem_read_pulse <= mem_rd;
         empty_flag <= fall_q | ~zero_cond;
         full_flag <= fall_q | ~cap_cond;
         output_valid_flag <= ~fall_q | zero_cond;
         input_room_flag <= ~fall_q | cap_cond;
         half_full_flag <= ~half_cond;
         if (sync_mode_q) begin
            if (wr_rise) begin
               almost_full_flag <= ~af_cond;
            end
            if (rd_rise) begin
               almost_empty_flag <= ~ae_cond;
            end
         end else begin
            if (wr_rise & af_cond) begin
               almost_full_flag <= 1'b0;
            end else if (rd_rise & ~af_cond) begin
               almost_full_flag <= 1'b1;
            end
            if (rd_rise & ae_cond) begin
               almost_empty_flag <= 1'b0;
            end else if (wr_rise & ~ae_cond) begin
               almost_empty_flag <= 1'b1;
            end
         end
      end
   end
endmodule

`default_nettype wire

// ---- verilog/fsf_regs.vh ----
/*
 * Constants for the FIFO status flag and offset access block: depth, widths,
 * offset register pointer codes, default offsets and control bundle layout.
 * Assumes the smallest depth of the family, 1,024 words, and a 9-bit offset port.
 */
`ifndef FSF_REGS_VH
`define FSF_REGS_VH

// fifo geometry
`define FSF_CNT_W 11
`define FSF_DEPTH 11'h400
`define FSF_HALF_P1 11'h201
`define FSF_OFS_W 10
`define FSF_LO_W 9
`define FSF_SER_BITS 20
`define FSF_DATA_W 36

// offset register pointer codes
`define FSF_PTR_E_LO 2'h0
`define FSF_PTR_E_HI 2'h1
`define FSF_PTR_F_LO 2'h2
`define FSF_PTR_F_HI 2'h3

// default offsets selected by {load_select, sel1, sel0} at master reset
`define FSF_DEF_010 10'h1ff
`define FSF_DEF_001 10'h0ff
`define FSF_DEF_000 10'h07f
`define FSF_DEF_011 10'h03f
`define FSF_DEF_100 10'h01f
`define FSF_DEF_110 10'h00f
`define FSF_DEF_101 10'h007
`define FSF_DEF_111 10'h003

// control bundle bit positions
`define FSF_CTL_W 20
`define FSF_B_MRST 0
`define FSF_B_PRS 1
`define FSF_B_LSEL 2
`define FSF_B_WEN 3
`define FSF_B_REN 4
`define FSF_B_SENA 5
`define FSF_B_SIN 6
`define FSF_B_FTS 7
`define FSF_B_FALL 8
`define FSF_B_FS1 9
`define FSF_B_FS0 10
`define FSF_B_DAT 11

`endif

// ---- verilog/fsf_pin_sync.v ----
/*
 * Three-stage pin synchroniser with agreement filter and rising-edge pulse.
 * Assumes pins change slower than the system clock can follow.
 */
`timescale 1ns/1ps
`default_nettype none

module fsf_pin_sync #(
   parameter W = 1
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // pin side
   input wire [W-1:0] pin_in,
   // filtered level and rise of bit 0
   output reg [W-1:0] level_q,
   output reg rise_q
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   reg [W-1:0] level_d;
   integer i;

   // a bit only moves once stages two and three agree
   always @* begin
      level_d = level_q;
      for (i = 0; i < W; i = i + 1) begin
         if (s2_q[i] == s3_q[i]) begin
            level_d[i] = s3_q[i];
         end
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= {W{1'b0}};
         s2_q <= {W{1'b0}};
         s3_q <= {W{1'b0}};
         level_q <= {W{1'b0}};
         rise_q <= 1'b0;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         level_q <= level_d;
         rise_q <= level_d[0] & ~level_q[0];
      end
   end
endmodule

`default_nettype wire

// ---- bench/fsf_flag_offset_asserts.sv ----
/*
 * Port checker for the flag and offset block, bound to its top module.
 * Assumes the enables stay steady for five clocks around each pin clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fsf_regs.vh"
module fsf_flag_offset_asserts (
   // system
   input wire logic clk,
   input wire logic arst_n,
   // access control
   input wire logic offset_load_select,
   input wire logic write_enable_n,
   input wire logic read_enable_n,
   // status
   input wire logic empty_flag,
   input wire logic output_valid_flag,
   input wire logic half_full_flag,
   input wire logic full_flag,
   input wire logic mem_write_pulse,
   input wire logic mem_read_pulse,
   input wire logic [`FSF_CNT_W-1:0] word_count,
   // offset read-back
   input wire logic [`FSF_DATA_W-1:0] offset_out_data,
   input wire logic offset_out_valid,
   input wire logic offset_out_ready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_stalled;
      offset_out_valid && !offset_out_ready;
   endsequence
   sequence s_held;
      offset_out_valid && $stable(offset_out_data);
   endsequence
   property p_out_hold;
      s_stalled |=> s_held;
   endproperty
   a_out_hold: assert property (p_out_hold) else $error("read-back word lost in a stall");
   property p_wr_cause;
      mem_write_pulse |-> $past(offset_load_select, 5) && !$past(write_enable_n, 5)
         ##1 !mem_write_pulse;
   endproperty
   a_wr_cause: assert property (p_wr_cause) else $error("stray memory write");
   property p_rd_cause;
      mem_read_pulse |-> $past(offset_load_select, 5) && !$past(read_enable_n, 5)
         ##1 !mem_read_pulse;
   endproperty
   a_rd_cause: assert property (p_rd_cause) else $error("stray memory read");
   property p_cnt_up;
      mem_write_pulse && !mem_read_pulse |-> word_count == $past(word_count) + 11'h001;
   endproperty
   a_cnt_up: assert property (p_cnt_up) else $error("count missed a write");
   property p_cnt_dn;
      mem_read_pulse && !mem_write_pulse |-> word_count == $past(word_count) - 11'h001;
   endproperty
   a_cnt_dn: assert property (p_cnt_dn) else $error("count missed a read");
   property p_empty;
      !empty_flag |-> word_count == 11'h000;
   endproperty
   a_empty: assert property (p_empty) else $error("empty flag with words held");
   property p_full;
      !full_flag |-> word_count == `FSF_DEPTH;
   endproperty
   a_full: assert property (p_full) else $error("full flag below depth");
   property p_half;
      !half_full_flag |-> word_count >= `FSF_HALF_P1;
   endproperty
   a_half: assert property (p_half) else $error("half full flag too early");
   property p_ovf;
      !output_valid_flag |-> word_count != 11'h000;
   endproperty
   a_ovf: assert property (p_ovf) else $error("output valid with no word");
endmodule
bind fsf_flag_offset fsf_flag_offset_asserts fsf_flag_offset_asserts_i (.clk, .arst_n,
   .offset_load_select, .write_enable_n, .read_enable_n, .empty_flag, .output_valid_flag,
   .half_full_flag, .full_flag, .mem_write_pulse, .mem_read_pulse, .word_count,
   .offset_out_data, .offset_out_valid, .offset_out_ready);
`default_nettype wire

// ---- bench/fsf_host_model.sv ----
/*
 * Host model: makes the pin clocks on request and consumes read-back words.
 * Assumes the bench sets the enables before asking for a clock pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module fsf_host_model (
   // system
   input wire logic clk,
   // requests: bit 0 write, bit 1 read, bit 2 serial clock
   input wire logic [2:0] req,
   input wire logic stall,
   output logic busy,
   // pin clocks, low outside a pulse
   output logic write_clock,
   output logic read_clock,
   output logic serial_load_clock,
   // read-back consumer
   output logic offset_out_ready
);
   logic [2:0] sel_q = 3'h0;
   logic [4:0] cnt_q = 5'h00;
   assign busy = cnt_q != 5'h00;
   assign offset_out_ready = !stall;
   // five clocks high, ten low: the block's filters need two each
   assign {serial_load_clock, read_clock, write_clock} = (cnt_q > 5'h0a) ? sel_q : 3'h0;
   always @(posedge clk) begin
      if (!busy && req != 3'h0) begin
         sel_q <= req;
         cnt_q <= 5'h0f;
      end else if (busy) begin
         cnt_q <= cnt_q - 5'h01;
      end
   end
endmodule
`default_nettype wire

// ---- bench/fsf_flag_offset_tb_top.sv ----
/*
 * Testbench for the flag and offset block, with the host model on its pins.
 * Assumes one pin operation at a time, paced by the host model.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
   $display("ERROR %0t: got %h expected %h", $time, a, e); end end
module fsf_flag_offset_tb_top;
   typedef struct {logic [10:0] cnt; logic [4:0] f;} fsf_row_t;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic master_reset_n = 1'b1;
   logic flag_timing_select = 1'b0;
   logic first_word_fall_through = 1'b0;
   logic [1:0] offset_select = 2'h0;
   logic offset_load_select = 1'b1;
   logic write_enable_n = 1'b1;
   logic read_enable_n = 1'b1;
   logic serial_enable_n = 1'b1;
   logic serial_data_in = 1'b0;
   logic [8:0] data_in = 9'h000;
   logic [2:0] req = 3'h0;
   logic stall = 1'b0;
   logic stall_seen = 1'b0;
   logic partial_reset_n = 1'b1;
   logic [35:0] got [$];
   logic [19:0] ser;
   int n_mismatch = 0;
   int tests_run = 0;
   int k;
   fsf_row_t rows [10];
   wire write_clock, read_clock, serial_load_clock, busy, offset_out_ready;
   wire empty_flag, output_valid_flag, almost_empty_flag, half_full_flag, almost_full_flag;
   wire full_flag, input_room_flag, mem_write_pulse, mem_read_pulse;
   wire offset_out_valid, offset_read_stall;
   wire [10:0] word_count;
   wire [35:0] offset_out_data;
   wire [4:0] fl = {empty_flag, almost_empty_flag, half_full_flag, almost_full_flag, full_flag};
   fsf_flag_offset fsf_flag_offset_i (.clk, .arst_n, .write_clock, .read_clock,
      .serial_load_clock, .master_reset_n, .partial_reset_n, .flag_timing_select,
      .first_word_fall_through, .offset_select, .offset_load_select, .write_enable_n,
      .read_enable_n, .serial_enable_n, .serial_data_in, .data_in, .empty_flag,
      .output_valid_flag, .almost_empty_flag, .half_full_flag, .almost_full_flag, .full_flag,
      .input_room_flag, .mem_write_pulse, .mem_read_pulse, .word_count, .offset_out_data,
      .offset_out_valid, .offset_out_ready, .offset_read_stall);
   fsf_host_model fsf_host_model_i (.clk, .req, .stall, .busy, .write_clock, .read_clock,
      .serial_load_clock, .offset_out_ready);
   always #5 clk = ~clk;
   always @(posedge clk) if (offset_read_stall === 1'b1) stall_seen <= 1'b1;
   // every accepted read-back word is kept in order for the checks
   always @(posedge clk) if (offset_out_valid === 1'b1 && offset_out_ready === 1'b1)
      got.push_back(offset_out_data);
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // c is {load select, write, read, serial enables}, r picks the pin clocks
   task automatic op(input logic [3:0] c, input logic [8:0] d, input logic [2:0] r);
      int i;
      @(posedge clk);
      {offset_load_select, write_enable_n, read_enable_n, serial_enable_n} <= c;
      data_in <= d;
      serial_data_in <= d[0];
      repeat (5) @(posedge clk);
      req <= r;
      @(posedge clk);
      req <= 3'h0;
      #1;
      for (i = 0; i < 40 && busy; i++) @(posedge clk);
      #1;
   endtask
   task automatic mreset(input logic fts, input logic fw, input logic lsel, input logic [1:0] s);
      @(posedge clk);
      master_reset_n <= 1'b0;
      flag_timing_select <= fts;
      first_word_fall_through <= fw;
      offset_load_select <= lsel;
      offset_select <= s;
      repeat (8) @(posedge clk);
      master_reset_n <= 1'b1;
      repeat (8) @(posedge clk);
   endtask
   task automatic pop(input logic [8:0] e);
      logic [35:0] w;
      w = 36'hx;
      for (int i = 0; i < 20 && got.size() == 0; i++) @(posedge clk);
      if (got.size() != 0) w = got.pop_front();
      `CHK(w, {27'h000_0000, e})
   endtask
   task automatic rd4(input logic [35:0] e);
      for (int j = 0; j < 4; j++) begin
         op(4'h5, 9'h000, 3'h2);
         pop(e[9*j+:9]);
      end
   endtask
   task automatic fill(input logic [10:0] t, input logic [3:0] c, input logic [2:0] r);
      for (int g = 0; g < 1100 && word_count !== t; g++) op(c, 9'h000, r);
   endtask
   initial begin
      repeat (90000) @(posedge clk);
      n_mismatch++;
      end_of_test;
   end
   initial begin
      rows = '{'{11'h000, 5'h07}, '{11'h001, 5'h17}, '{11'h005, 5'h17}, '{11'h006, 5'h1f},
         '{11'h200, 5'h1f}, '{11'h201, 5'h1b}, '{11'h3f9, 5'h1b}, '{11'h3fa, 5'h19},
         '{11'h3ff, 5'h19}, '{11'h400, 5'h18}};
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      `CHK({empty_flag, output_valid_flag, almost_empty_flag, half_full_flag, almost_full_flag,
         full_flag, input_room_flag, offset_out_valid, word_count}, {8'h5c, 11'h000})
      $display("test reset done");
      mreset(1'b0, 1'b0, 1'b0, 2'h0);
      rd4({9'h000, 9'h07f, 9'h000, 9'h07f});
      op(4'h3, 9'h005, 3'h1);
      op(4'h3, 9'h1fe, 3'h1);
      op(4'h1, 9'h0aa, 3'h3);
      op(4'hf, 9'h0aa, 3'h7);
      op(4'h3, 9'h006, 3'h1);
      op(4'h3, 9'h000, 3'h1);
      `CHK({offset_out_valid, word_count}, 12'h000)
      `CHK({input_room_flag, output_valid_flag}, 2'h3)
      rd4({9'h000, 9'h006, 9'h000, 9'h005});
      $display("test parallel offsets done");
      for (k = 0; k < 10; k++) begin
         fill(rows[k].cnt, 4'hb, 3'h1);
         `CHK({fl, word_count}, {rows[k].f, rows[k].cnt})
      end
      op(4'hb, 9'h000, 3'h1);
      `CHK(word_count, 11'h400)
      for (k = 9; k >= 0; k--) begin
         fill(rows[k].cnt, 4'hd, 3'h2);
         `CHK({fl, word_count}, {rows[k].f, rows[k].cnt})
      end
      op(4'hd, 9'h000, 3'h2);
      `CHK(word_count, 11'h000)
      $display("test standard flags done");
      mreset(1'b1, 1'b1, 1'b1, 2'h3);
      `CHK({output_valid_flag, empty_flag}, 2'h3)
      ser = {10'h2c3, 10'h004};
      for (k = 0; k < 20; k++) op(4'h6, {8'h00, ser[k]}, 3'h4);
      // parallel writes must not land while serial loading is selected
      op(4'h3, 9'h1aa, 3'h1);
      rd4({9'h001, 9'h0c3, 9'h000, 9'h004});
      fill(11'h007, 4'hb, 3'h1);
      `CHK({output_valid_flag, almost_empty_flag}, 2'h0)
      op(4'hd, 9'h000, 3'h2);
      `CHK({word_count, almost_empty_flag}, {11'h006, 1'b1})
      `CHK(input_room_flag, 1'b0)
      $display("test serial and sync flags done");
      @(posedge clk);
      stall <= 1'b1;
      for (k = 0; k < 3; k++) op(4'h5, 9'h000, 3'h2);
      `CHK(stall_seen, 1'b1)
      stall <= 1'b0;
      pop(9'h004);
      pop(9'h000);
      // partial reset clears the count but must leave the read pointer at the full low word
      partial_reset_n <= 1'b0;
      repeat (8) @(posedge clk);
      partial_reset_n <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      `CHK(word_count, 11'h000)
      op(4'h5, 9'h000, 3'h2);
      pop(9'h0c3);
      $display("test read-back stall done");
      end_of_test;
   end
endmodule
`default_nettype wire
